// >>> design/ccr_pkg.sv
package ccr_pkg;
   // ----------------------------------------
   // Register map and field layout
   // ----------------------------------------
   // The printed offset (1) is not a multiple of four, so it is kept as an index.
   localparam logic [3:0] CMD_INDEX = 4'h1;
   localparam logic [3:0] STAT_INDEX = 4'h2;
   localparam logic [3:0] CORE_INDEX = 4'h3;
   localparam logic [31:0] CMD_ADDR = {26'h0, CMD_INDEX, 2'b00};
   localparam logic [31:0] STAT_ADDR = {26'h0, STAT_INDEX, 2'b00};
   localparam logic [31:0] CORE_ADDR = {26'h0, CORE_INDEX, 2'b00};
   localparam int BIT_SEND = 0;
   localparam int BIT_ABORT = 1;
   localparam int BIT_FREE = 2;
   localparam int BIT_CLR_OVR = 3;
   localparam int BIT_SLEEP = 4;
   localparam int BIT_WAKE_SEL = 5;
   localparam int BIT_IN1_SW = 6;
   localparam int BIT_IN0_SW = 7;
   localparam logic [3:0] STROBE_READ = 4'hF;
   localparam logic [1:0] SW_RESET = 2'b11;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Least spacing between two buffer releases, in system clock cycles.
   localparam logic [1:0] FREE_GAP = 2'h3;
   typedef enum logic [1:0] {
      ST_AWAKE,
      ST_SLEEP,
      ST_WAIT_IDLE
   } ccr_pwr_t;
endpackage

// >>> design/ccr_wake.sv
// ----------------------------------------
// Input routing and wake-up detection
// ----------------------------------------
module ccr_wake (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in0_sw,
   input wire logic in1_sw,
   input wire logic wake_select,
   input wire logic comparator_in0,
   input wire logic comparator_in1,
   output logic bus_input0,
   output logic bus_input1,
   output logic bus_activity
);
   logic [2:0] c0_r;
   logic [2:0] c1_r;
   logic c0_s;
   logic c1_s;
   logic single_act;
   logic diff_act;

   // Three-stage synchronisers; a change counts once stages two and three agree.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c0_r <= 3'h7;
         c1_r <= 3'h0;
         c0_s <= 1'b1;
         c1_s <= 1'b0;
      end else begin
         c0_r <= {c0_r[1:0], comparator_in0};
         c1_r <= {c1_r[1:0], comparator_in1};
         if (c0_r[1] == c0_r[2]) c0_s <= c0_r[2];
         if (c1_r[1] == c1_r[2]) c1_s <= c1_r[2];
      end
   end

   // switch decode
   // A switched-off input is modelled as sitting at the half-supply reference,
   // taken here as its recessive level; the 0,0 setting leaves routing as 1,1.
   assign bus_input0 = (in0_sw || !in1_sw) ? c0_s : 1'b1;
   assign bus_input1 = (in1_sw || !in0_sw) ? c1_s : 1'b0;

   // wake mode select
   // Single-ended mode sees either wire leave its reference level; differential
   // mode needs both wires dominant, which rejects noise on one wire.
   assign single_act = !bus_input0 || bus_input1;
   assign diff_act = !bus_input0 && bus_input1;
   assign bus_activity = wake_select ? single_act : diff_act;
endmodule

// >>> design/ccr_top.sv
module ccr_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ctrl_reset_req,
   input wire logic irq_pending,
   input wire logic tx_started,
   input wire logic tx_done,
   input wire logic rx_stored,
   input wire logic rx_overrun,
   input wire logic bus_free,
   input wire logic comparator_in0,
   input wire logic comparator_in1,
   output logic bus_input0,
   output logic bus_input1,
   output logic tx_pending,
   output logic tx_active,
   output logic free_rx_strobe,
   output logic overrun_flag,
   output logic send_done_flag,
   output logic send_buffer_free,
   output logic rx_status_flag,
   output logic asleep,
   output logic rx_enable,
   output logic wake_irq
);
   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   logic [31:0] awaddr_r;
   logic aw_held_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic w_held_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic wr_fire;
   logic wr_cmd;
   logic wr_lane0;
   logic [7:0] wr_byte;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign wr_fire = aw_held_r && w_held_r;
   assign wr_cmd = wr_fire && (awaddr_r == ccr_pkg::CMD_ADDR);
   assign wr_lane0 = wr_cmd && wstrb_r[0];
   assign wr_byte = wdata_r[7:0];

   // Address and data are latched independently, in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 32'h0000_0000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= ccr_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_cmd ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Command strobes and stored bits
   // ----------------------------------------
   logic send_stb;
   logic abort_stb;
   logic free_stb;
   logic clr_ovr_stb;
   logic sleep_cmd_r;
   logic wake_select_r;
   logic [1:0] sw_r;
   logic [1:0] free_gap_r;

   assign send_stb = wr_lane0 && wr_byte[ccr_pkg::BIT_SEND];
   assign abort_stb = wr_lane0 && wr_byte[ccr_pkg::BIT_ABORT];
   // release receive buffer
   // A release inside the spacing window is dropped, as on the real part.
   assign free_stb = wr_lane0 && wr_byte[ccr_pkg::BIT_FREE] && (free_gap_r == 2'h0);
   assign clr_ovr_stb = wr_lane0 && wr_byte[ccr_pkg::BIT_CLR_OVR];
   assign free_rx_strobe = free_stb;

   // Stored control bits; switches change only under controller reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_cmd_r <= 1'b0;
         wake_select_r <= 1'b0;
         sw_r <= ccr_pkg::SW_RESET;
         free_gap_r <= 2'h0;
      end else begin
         if (wr_lane0) begin
            sleep_cmd_r <= wr_byte[ccr_pkg::BIT_SLEEP];
            wake_select_r <= wr_byte[ccr_pkg::BIT_WAKE_SEL];
         end
         if (wr_lane0 && ctrl_reset_req) begin
            sw_r <= {wr_byte[ccr_pkg::BIT_IN0_SW], wr_byte[ccr_pkg::BIT_IN1_SW]};
         end
         if (free_stb) begin
            free_gap_r <= ccr_pkg::FREE_GAP - 2'h1;
         end else if (free_gap_r != 2'h0) begin
            free_gap_r <= free_gap_r - 2'h1;
         end
      end
   end

   // ----------------------------------------
   // Transmit request and status flags
   // ----------------------------------------
   logic tx_pending_r;
   logic tx_active_r;
   logic done_r;
   logic ovr_r;
   logic rbs_r;

   assign tx_pending = tx_pending_r;
   assign tx_active = tx_active_r;
   assign send_done_flag = done_r;
   assign overrun_flag = ovr_r;
   assign rx_status_flag = rbs_r;
   assign send_buffer_free = !tx_pending_r && !tx_active_r;

   // Flags that hardware sets give the set priority over a same-cycle clear.
   always_ff @(posedge aclk) begin
      if (!aresetn || ctrl_reset_req) begin
         tx_pending_r <= 1'b0;
         tx_active_r <= 1'b0;
         done_r <= 1'b1;
         ovr_r <= 1'b0;
         rbs_r <= 1'b0;
      end else begin
         if (tx_pending_r && tx_started) begin
            tx_pending_r <= 1'b0;
            tx_active_r <= 1'b1;
         end else if (send_stb && send_buffer_free) begin
            tx_pending_r <= 1'b1;
         end else if (abort_stb) begin
            tx_pending_r <= 1'b0;
         end
         if (tx_active_r && tx_done) begin
            tx_active_r <= 1'b0;
         end
         if (tx_active_r && tx_done) begin
            done_r <= 1'b1;
         end else if (send_stb && send_buffer_free) begin
            done_r <= 1'b0;
         end
         if (rx_overrun) begin
            ovr_r <= 1'b1;
         end else if (clr_ovr_stb) begin
            ovr_r <= 1'b0;
         end
         if (rx_stored) begin
            rbs_r <= 1'b1;
         end else if (free_stb) begin
            rbs_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Sleep control and wake-up
   // ----------------------------------------
   logic bus_activity;
   ccr_pkg::ccr_pwr_t pwr_r;
   ccr_pkg::ccr_pwr_t pwr_nxt;
   logic wake_irq_r;
   logic wake_nxt;

   ccr_wake u_wake (
      .aclk(aclk),
      .aresetn(aresetn),
      .in0_sw(sw_r[1]),
      .in1_sw(sw_r[0]),
      .wake_select(wake_select_r),
      .comparator_in0(comparator_in0),
      .comparator_in1(comparator_in1),
      .bus_input0(bus_input0),
      .bus_input1(bus_input1),
      .bus_activity(bus_activity)
   );

   always_comb begin
      pwr_nxt = pwr_r;
      wake_nxt = 1'b0;
      case (pwr_r)
         ccr_pkg::ST_AWAKE: begin
            if (sleep_cmd_r && !irq_pending && !bus_activity && !tx_active_r) pwr_nxt = ccr_pkg::ST_SLEEP;
         end
         ccr_pkg::ST_SLEEP: begin
            if (bus_activity) begin
               pwr_nxt = ccr_pkg::ST_WAIT_IDLE;
               wake_nxt = 1'b1;
            end else if (!sleep_cmd_r) begin
               pwr_nxt = ccr_pkg::ST_AWAKE;
               wake_nxt = 1'b1;
            end
         end
         ccr_pkg::ST_WAIT_IDLE: begin
            if (bus_free) pwr_nxt = ccr_pkg::ST_AWAKE;
         end
         default: pwr_nxt = ccr_pkg::ST_AWAKE;
      endcase
   end

   // A bus wake leaves the sleep bit set; software must clear it to stop re-entry.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_r <= ccr_pkg::ST_AWAKE;
         wake_irq_r <= 1'b0;
      end else begin
         pwr_r <= pwr_nxt;
         wake_irq_r <= wake_nxt;
      end
   end

   assign asleep = (pwr_r == ccr_pkg::ST_SLEEP);
   assign rx_enable = (pwr_r == ccr_pkg::ST_AWAKE);
   assign wake_irq = wake_irq_r;

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [7:0] cmd_view;
   logic [7:0] stat_view;
   logic [7:0] core_view;

   assign cmd_view = {sw_r, wake_select_r, asleep, ccr_pkg::STROBE_READ};
   assign stat_view = {4'h0, done_r, send_buffer_free, ovr_r, rbs_r};
   assign core_view = {6'h00, tx_active_r, tx_pending_r};
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Reads answer one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= ccr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rresp_r <= ccr_pkg::RESP_OKAY;
         if (s_axi_araddr == ccr_pkg::CMD_ADDR) rdata_r <= {24'h00_0000, cmd_view};
         else if (s_axi_araddr == ccr_pkg::STAT_ADDR) rdata_r <= {24'h00_0000, stat_view};
         else if (s_axi_araddr == ccr_pkg::CORE_ADDR) rdata_r <= {24'h00_0000, core_view};
         else begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= ccr_pkg::RESP_SLVERR;
         end
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule

// >>> bench/ccr_properties.sv
// ----------------------------------------
// Command register checker
// ----------------------------------------
module ccr_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic ctrl_reset_req,
   input wire logic irq_pending,
   input wire logic rx_stored,
   input wire logic rx_overrun,
   input wire logic tx_pending,
   input wire logic free_rx_strobe,
   input wire logic overrun_flag,
   input wire logic send_done_flag,
   input wire logic send_buffer_free,
   input wire logic rx_status_flag,
   input wire logic asleep,
   input wire logic wake_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cmd_hit_r;
   logic [7:0] wbyte_r;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Address and data are caught separately, since the bus may take them apart.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_hit_r <= 1'b0;
         wbyte_r <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) cmd_hit_r <= (s_axi_awaddr == ccr_pkg::CMD_ADDR);
         if (s_axi_wvalid && s_axi_wready) wbyte_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
   end
   // The response rises one edge after the strobes act, so flags have already moved there.
   // What the strobe itself saw is therefore taken with $past.
   sequence cmd_wr_s;
      $rose(s_axi_bvalid) && cmd_hit_r;
   endsequence
   sequence cmd_rd_s;
      s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == ccr_pkg::CMD_ADDR;
   endsequence
   send_queues_a: assert property (cmd_wr_s ##0 (wbyte_r[0] && $past(send_buffer_free) && !$past(ctrl_reset_req))
      |-> tx_pending && !send_done_flag) else $error("send request not queued");
   abort_pending_a: assert property (cmd_wr_s ##0 (wbyte_r[1:0] == 2'h2) |=> !tx_pending)
      else $error("abort left request pending");
   overrun_clear_a: assert property (cmd_wr_s ##0 (wbyte_r[3] && !$past(rx_overrun)) |-> !overrun_flag)
      else $error("overrun flag not cleared");
   free_empties_a: assert property (free_rx_strobe && !rx_stored |=> !rx_status_flag)
      else $error("receive status not emptied");
   strobe_gap_a: assert property (free_rx_strobe |=> !free_rx_strobe [*2])
      else $error("release strobes too close");
   cmd_ones_a: assert property (cmd_rd_s |=> s_axi_rvalid && s_axi_rdata[3:0] == 4'hF)
      else $error("command low bits not read as one");
   sleep_guard_a: assert property ($rose(asleep) |-> $past(irq_pending) == 1'b0)
      else $error("slept with interrupt pending");
   wake_irq_a: assert property ($fell(asleep) |-> ##[0:1] wake_irq)
      else $error("wake without interrupt");
endmodule
bind ccr_top ccr_properties chk_u (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid, .ctrl_reset_req,
   .irq_pending, .rx_stored, .rx_overrun, .tx_pending, .free_rx_strobe, .overrun_flag, .send_done_flag,
   .send_buffer_free, .rx_status_flag, .asleep, .wake_irq
);

// >>> bench/ccr_bus_model.sv
// ----------------------------------------
// Bus transceiver model
// ----------------------------------------
module ccr_bus_model (
   input wire logic aclk,
   input wire logic dominant,
   input wire logic idle_req,
   input wire logic one_wire,
   output logic comparator_in0,
   output logic comparator_in1,
   output logic bus_free
);
   timeunit 1ns;
   timeprecision 1ps;
   // Recessive puts input 0 high and input 1 low; dominant swaps them.
   assign comparator_in0 = !dominant;
   // One_wire pulls only input 1 dominant, as when the other wire is disturbed.
   assign comparator_in1 = dominant || one_wire;
   // Bus-free is only reported once dominant is back low; one_wire is not looked at.
   always_ff @(posedge aclk) begin
      bus_free <= idle_req && !dominant;
   end
endmodule

// >>> bench/test_can_command_register_logic.sv
// ----------------------------------------
// Command register testbench
// ----------------------------------------
module test_can_command_register_logic;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] CMD_A = ccr_pkg::CMD_ADDR;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb, ev;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic ctrl_reset_req, irq_pending, bus_free, comparator_in0, comparator_in1, dom, idle_req, one_wire;
   logic bus_input0, bus_input1, tx_pending, tx_active, free_rx_strobe, overrun_flag;
   logic send_done_flag, send_buffer_free, rx_status_flag, asleep, rx_enable, wake_irq;
   int failures, total_checks, cyc, n_free, n_wake;
   // Rows: write address, data, response; read address, data, response.
   logic [31:0] tbl [4][6] = '{
      '{CMD_A, 8'h00, ccr_pkg::RESP_OKAY, CMD_A, 8'hCF, ccr_pkg::RESP_OKAY},
      '{CMD_A, 8'h20, ccr_pkg::RESP_OKAY, CMD_A, 8'hEF, ccr_pkg::RESP_OKAY},
      '{8'h10, 8'hFF, ccr_pkg::RESP_SLVERR, ccr_pkg::STAT_ADDR, 8'h0C, ccr_pkg::RESP_OKAY},
      '{CMD_A, 8'h08, ccr_pkg::RESP_OKAY, 8'h10, 8'h00, ccr_pkg::RESP_SLVERR}};
   ccr_top dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrl_reset_req, .irq_pending,
      .tx_started(ev[0]), .tx_done(ev[1]), .rx_stored(ev[2]), .rx_overrun(ev[3]), .bus_free, .comparator_in0,
      .comparator_in1, .bus_input0, .bus_input1, .tx_pending, .tx_active, .free_rx_strobe, .overrun_flag,
      .send_done_flag, .send_buffer_free, .rx_status_flag, .asleep, .rx_enable, .wake_irq
   );
   ccr_bus_model bus_u (.aclk, .dominant(dom), .idle_req, .one_wire, .comparator_in0, .comparator_in1, .bus_free);
   // Free-running clock, 8 ns period.
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Bus tasks end one edge late, so flag updates have landed and no signal is set twice at once.
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic pls(input int k);
      @(posedge aclk);
      ev[k] <= 1'b1;
      @(posedge aclk);
      ev[k] <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task end_sim();
      $display("Checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Event counters and the hang limit; the run needs well under a thousand cycles.
   always @(posedge aclk) begin
      cyc++;
      if (free_rx_strobe === 1'b1) n_free++;
      if (wake_irq === 1'b1) n_wake++;
      if (cyc == 5000) begin
         failures++;
         end_sim();
      end
   end
   // Main sequence.
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {ctrl_reset_req, irq_pending, dom, idle_req, one_wire, ev} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (tbl[i]) begin
         wr(tbl[i][0], tbl[i][1]);
         chk("bresp", tbl[i][2], resp);
         rd(tbl[i][3]);
         chk("rresp", tbl[i][5], resp);
         chk("rdata", tbl[i][4], rdat);
      end
      $display("Register table done");
      wr(CMD_A, 32'h0000_0001);
      chk("queued", 2'h2, {tx_pending, send_done_flag});
      wr(CMD_A, 32'h0000_0000);
      chk("kept", 1'b1, tx_pending);
      wr(CMD_A, 32'h0000_0002);
      chk("aborted", 3'h2, {tx_pending, send_buffer_free, send_done_flag});
      wr(CMD_A, 32'h0000_0001);
      pls(0);
      wr(CMD_A, 32'h0000_0002);
      chk("in flight", 1'b1, tx_active);
      pls(1);
      chk("sent", 3'h3, {tx_active, send_buffer_free, send_done_flag});
      $display("Transmit test done");
      pls(2);
      pls(3);
      wr(CMD_A, 32'h0000_0004);
      chk("released", 2'h1, {rx_status_flag, overrun_flag});
      wt(3);
      wr(CMD_A, 32'h0000_000C);
      chk("overrun", 1'b0, overrun_flag);
      chk("releases", 2, n_free);
      $display("Receive test done");
      irq_pending <= 1'b1;
      wr(CMD_A, 32'h0000_0010);
      wt(3);
      chk("held awake", 1'b0, asleep);
      irq_pending <= 1'b0;
      wt(3);
      rd(CMD_A);
      chk("asleep", 10'h2DF, {asleep, rx_enable, rdat[7:0]});
      wr(CMD_A, 32'h0000_0000);
      wt(2);
      chk("sw wake", 2'h1, {asleep, rx_enable});
      chk("wake irq", 1, n_wake);
      for (int m = 0; m < 2; m++) begin
         wr(CMD_A, m ? 32'h0000_0030 : 32'h0000_0010);
         wt(3);
         chk("slept", 1'b1, asleep);
         one_wire <= 1'b1;
         wt(8);
         chk("one wire", !m, asleep);
         dom <= 1'b1;
         wt(8);
         chk("bus wake", 2'h0, {asleep, rx_enable});
         chk("wake irq", 2 + m, n_wake);
         wr(CMD_A, 32'h0000_0000);
         dom <= 1'b0;
         one_wire <= 1'b0;
         wt(8);
         chk("no bus free", 1'b0, rx_enable);
         idle_req <= 1'b1;
         wt(1);
         idle_req <= 1'b0;
         wt(3);
         chk("resumed", 1'b1, rx_enable);
      end
      $display("Sleep test done");
      ctrl_reset_req <= 1'b1;
      dom <= 1'b1;
      for (int s = 3; s >= 0; s--) begin
         wr(CMD_A, 32'(s) << 6);
         rd(CMD_A);
         wt(5);
         chk("switches", s, rdat[7:6]);
         chk("route0", s == 1, bus_input0);
         chk("route1", s != 2, bus_input1);
      end
      wr(CMD_A, 32'h0000_00C0);
      ctrl_reset_req <= 1'b0;
      dom <= 1'b0;
      $display("Switch test done");
      wr(CMD_A, 32'h0000_0001);
      aresetn <= 1'b0;
      wt(2);
      aresetn <= 1'b1;
      chk("reset", 5'h07, {tx_pending, asleep, send_buffer_free, send_done_flag, rx_enable});
      rd(CMD_A);
      chk("reset cmd", 32'h0000_00CF, rdat);
      $display("Reset test done");
      end_sim();
   end
endmodule
